// ===== temp_alert_defines.vh
// constants for the alert and critical-temperature signalling block
`ifndef TEMP_ALERT_DEFINES_VH
`define TEMP_ALERT_DEFINES_VH
// register word offsets on the avalon bus
`define OFS_LOCAL_TEMP   4'h0
`define OFS_REM_TEMP_HI  4'h1
`define OFS_REM_TEMP_LO  4'h2
`define OFS_STATUS       4'h3
`define OFS_CONFIG       4'h4
`define OFS_MODE         4'h5
`define OFS_ENH_CONFIG   4'h6
`define OFS_LOCAL_HIGH   4'h7
`define OFS_REM_HIGH_HI  4'h8
`define OFS_REM_HIGH_LO  4'h9
`define OFS_REM_LOW_HI   4'hA
`define OFS_REM_LOW_LO   4'hB
`define OFS_CRIT_LIMIT   4'hC
`define OFS_CRIT_HYST    4'hD
// field positions
`define CFG_MASK_BIT     7
`define CFG_UNLOCK_BIT   1
`define MODE_CMP_BIT     0
`define MODE_ALCFG_BIT   1
`define ENH_USF_BIT      3
`define ST_BUSY_BIT      7
`define ST_LHIGH_BIT     4
`define ST_RHIGH_BIT     3
`define ST_RLOW_BIT      2
`define ST_CRIT_BIT      1
`define ST_DFAULT_BIT    0
// mask of status bits that may raise the alert
`define ST_ALERT_MASK    8'h1E
// reset values
`define RST_CRIT_LIMIT   8'h55
`define RST_CRIT_HYST    8'h0A
`define RST_LOCAL_HIGH   8'h46
`define RST_REM_HIGH     16'h5500
`define RST_REM_LOW      16'h0000
// smbus addresses, seven bits
`define SMB_OWN_ADDR     7'h4C
`define SMB_ARA_ADDR     7'h0C
`endif

// ===== sync2.v
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module sync2 #(
	parameter WIDTH = 1
) (
	input  wire             clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] din,
	output reg  [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] meta_r;	// first stage, read only by second

	// two stages, idle-high reset as the bus lines rest high
	always @(posedge clk) begin
		if (rst) begin
			meta_r <= {WIDTH{1'b1}};
			dout   <= {WIDTH{1'b1}};
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule

// ===== temp_format.v
// clamps raw readings into left-justified register formats
`timescale 1ns/1ns
module temp_format (
	input  wire [15:0] remote_meas,
	input  wire [11:0] local_meas,
	input  wire        unsigned_sel,
	output reg  [15:0] remote_word,
	output reg  [7:0]  local_byte
);
	reg [10:0] rem11;	// clamped eleven-bit value

	// saturate instead of wrapping, remote per selected format, local always signed
	always @* begin
		rem11 = 11'h000;
		if (unsigned_sel) begin
			if (remote_meas[15])
				rem11 = 11'h000;	// below zero pins to zero
			else if (remote_meas[14:11] != 4'h0)
				rem11 = 11'h7FF;	// above full scale
			else
				rem11 = remote_meas[10:0];
		end else begin
			if (!remote_meas[15] && remote_meas[14:10] != 5'h00)
				rem11 = 11'h3FF;	// positive overrange
			else if (remote_meas[15] && remote_meas[14:10] != 5'h1F)
				rem11 = 11'h400;	// negative overrange
			else
				rem11 = remote_meas[10:0];
		end
		remote_word = {rem11, 5'h00};
		if (!local_meas[11] && local_meas[10:7] != 4'h0)
			local_byte = 8'h7F;
		else if (local_meas[11] && local_meas[10:7] != 4'hF)
			local_byte = 8'h80;
		else
			local_byte = local_meas[7:0];
	end
endmodule

// ===== temp_alert_crit.v
// alert and critical-temperature signalling with smbus target and avalon registers
//
// Contract
// - comparator mode releases alert when condition clears
// - comparator behaviour only with mode bit; resets clear
// - mode bit low gives latched interrupt behaviour
// - status read in interrupt mode sets mask, releases
// - status bits cleared by read, set again
// - alerting device sends address, host nacks, stops
// - address sent in ara sets mask, releases alert
// - alert response address is 0001100
// - answer ara only while alert config low
// - mask disables alert; mask, config reset low
// - critical output follows critical status flag
// - critical flag clears at limit minus hysteresis
// - critical limit locked until unlock bit set
// - unsigned select sets critical format and range
// - never drive smbus clock, no stretching
// - fixed target address 1001100
// - left-justified temperature word, unused bits zero
// - temperatures saturate at full scale
// - remote values eleven-bit, eighth-degree steps
// - compare every reading with limits, set status
// - unmasked status bits pull alert low
`timescale 1ns/1ns
`include "temp_alert_defines.vh"
module temp_alert_crit (
	input  wire        clk,
	input  wire        rst,
	// avalon-mm slave
	input  wire [3:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	output reg  [31:0] readdata,
	output wire        waitrequest,
	// measurement side, same clock domain
	input  wire        conv_done,
	input  wire [15:0] remote_meas,
	input  wire [11:0] local_meas,
	input  wire        conv_busy,
	input  wire        diode_fault,
	// smbus pins
	input  wire        smb_clk,
	input  wire        smb_dat_in,
	output wire        smb_dat_out,
	output wire        smb_dat_oe,
	// open-drain outputs
	output wire        alert_out,
	output wire        alert_oe,
	output wire        critical_temp_out,
	output wire        critical_temp_oe
);
	////////////////////////////////////////////////////////////////////////////////
	// smbus state codes
	localparam S_IDLE = 3'd0;
	localparam S_ADDR = 3'd1;
	localparam S_ACK  = 3'd2;
	localparam S_TX   = 3'd3;
	localparam S_RACK = 3'd4;
	localparam S_RX   = 3'd5;
	localparam S_NEXT = 3'd6;

	// registers reachable by software, except live_r and critical_status_flag_r
	reg        alert_mask_r;	// disables alert output
	reg        critical_limit_unlock_r;	// lets critical limit be written
	reg        comparator_mode_r;	// comparator versus interrupt
	reg        alert_config_r;	// high blocks ara answers
	reg        unsigned_format_select_r;	// unsigned temperature format
	reg [7:0]  local_high_limit_r;	// local high limit
	reg [15:0] remote_high_r;	// remote high limit, left justified
	reg [15:0] remote_low_r;	// remote low limit, left justified
	reg [7:0]  critical_limit_r;	// critical limit, whole degrees
	reg [7:0]  critical_hysteresis_r;	// critical hysteresis
	reg [15:0] remote_temp_value_r;	// last remote reading
	reg [7:0]  local_temp_value_r;	// last local reading
	reg [7:0]  status_r;	// sticky alert status
	reg [7:0]  live_r;	// limit conditions of last reading
	reg        critical_status_flag_r;	// hysteretic critical flag

	// bus handshake
	reg        ack_r;	// second cycle of a request
	wire       rd_fire;	// read completes this edge
	wire       wr_fire;	// write completes this edge

	// formatted readings
	wire [15:0] remote_word;
	wire [7:0]  local_byte;

	// smbus engine
	wire [1:0] pins_s;	// synchronised clock and data
	reg        scl_d_r;	// previous synchronised clock
	reg        sda_d_r;	// previous synchronised data
	reg  [2:0] smb_state_r;
	reg  [3:0] bit_cnt_r;
	reg  [7:0] shreg_r;
	reg        sda_oe_r;	// drive data low
	reg        rd_mode_r;	// read transfer
	reg        ara_mode_r;	// transfer is an alert response
	reg        ara_done_r;	// pulse: own address sent in ara

	wire scl = pins_s[1];
	wire sda = pins_s[0];
	wire scl_rise = scl & ~scl_d_r;
	wire scl_fall = ~scl & scl_d_r;
	wire start_c = scl & scl_d_r & sda_d_r & ~sda;
	wire stop_c = scl & scl_d_r & ~sda_d_r & sda;

	// alert decisions
	wire       alert_active;
	wire [7:0] pending = status_r & `ST_ALERT_MASK;

	////////////////////////////////////////////////////////////////////////////////
	// signed value helpers

	// extend a left-justified word to thirteen signed eighths
	function [12:0] ext13;
		input [15:0] w;
		input        unsigned_format_select;
		begin
			ext13 = unsigned_format_select ? {2'b00, w[15:5]} : {{2{w[15]}}, w[15:5]};
		end
	endfunction

	// extend a one-byte degree value to eleven signed bits
	function [10:0] ext_deg;
		input [7:0] b;
		input       unsigned_format_select;
		begin
			ext_deg = unsigned_format_select ? {3'b000, b} : {{3{b[7]}}, b};
		end
	endfunction

	wire [12:0] rt13 = ext13(remote_word, unsigned_format_select_r);
	wire [12:0] rh13 = ext13(remote_high_r, unsigned_format_select_r);
	wire [12:0] rl13 = ext13(remote_low_r, unsigned_format_select_r);
	// whole degrees, floor of the eighths value
	wire [10:0] rt_deg = {rt13[12], rt13[12:3]};
	wire [10:0] crit_deg = ext_deg(critical_limit_r, unsigned_format_select_r);
	wire [10:0] crit_clr = crit_deg - {3'b000, critical_hysteresis_r};
	wire        over_crit = $signed(rt_deg) > $signed(crit_deg);
	wire        below_clr = $signed(rt_deg) <= $signed(crit_clr);

	////////////////////////////////////////////////////////////////////////////////
	// submodules

	// clamping and left justification of readings
	temp_format u_format (
		.remote_meas  (remote_meas),
		.local_meas   (local_meas),
		.unsigned_sel (unsigned_format_select_r),
		.remote_word  (remote_word),
		.local_byte   (local_byte)
	);

	// smbus pins come from another domain
	sync2 #(.WIDTH(2)) u_sync (
		.clk  (clk),
		.rst  (rst),
		.din  ({smb_clk, smb_dat_in}),
		.dout (pins_s)
	);

	////////////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle per request

	assign waitrequest = (read | write) & ~ack_r;
	assign rd_fire = read & ack_r;
	assign wr_fire = write & ack_r;

	// wait-cycle generator and read data capture
	always @(posedge clk) begin
		if (rst) begin
			ack_r    <= 1'b0;
			readdata <= 32'h00000000;
		end else begin
			ack_r <= (read | write) & ~ack_r;
			if (read & ~ack_r) begin
				case (address)
				`OFS_LOCAL_TEMP:  readdata <= {24'h000000, local_temp_value_r};
				`OFS_REM_TEMP_HI: readdata <= {24'h000000, remote_temp_value_r[15:8]};
				`OFS_REM_TEMP_LO: readdata <= {24'h000000, remote_temp_value_r[7:0]};
				`OFS_STATUS:      readdata <= {24'h000000, status_r};
				`OFS_CONFIG:      readdata <= {24'h000000, alert_mask_r, 5'h00,
					critical_limit_unlock_r, 1'b0};
				`OFS_MODE:        readdata <= {30'h00000000, alert_config_r,
					comparator_mode_r};
				`OFS_ENH_CONFIG:  readdata <= {28'h0000000, unsigned_format_select_r,
					3'h0};
				`OFS_LOCAL_HIGH:  readdata <= {24'h000000, local_high_limit_r};
				`OFS_REM_HIGH_HI: readdata <= {24'h000000, remote_high_r[15:8]};
				`OFS_REM_HIGH_LO: readdata <= {24'h000000, remote_high_r[7:0]};
				`OFS_REM_LOW_HI:  readdata <= {24'h000000, remote_low_r[15:8]};
				`OFS_REM_LOW_LO:  readdata <= {24'h000000, remote_low_r[7:0]};
				`OFS_CRIT_LIMIT:  readdata <= {24'h000000, critical_limit_r};
				`OFS_CRIT_HYST:   readdata <= {24'h000000, critical_hysteresis_r};
				default:          readdata <= 32'h00000000;	// unmapped reads zero
				endcase
			end
		end
	end

	// software-written configuration and limits
	always @(posedge clk) begin
		if (rst) begin
			critical_limit_unlock_r  <= 1'b0;
			comparator_mode_r        <= 1'b0;
			alert_config_r           <= 1'b0;
			unsigned_format_select_r <= 1'b0;
			local_high_limit_r       <= `RST_LOCAL_HIGH;
			remote_high_r            <= `RST_REM_HIGH;
			remote_low_r             <= `RST_REM_LOW;
			critical_limit_r         <= `RST_CRIT_LIMIT;
			critical_hysteresis_r    <= `RST_CRIT_HYST;
		end else if (wr_fire) begin
			case (address)
			`OFS_CONFIG:      critical_limit_unlock_r <= writedata[`CFG_UNLOCK_BIT];
			`OFS_MODE: begin
				comparator_mode_r <= writedata[`MODE_CMP_BIT];
				alert_config_r    <= writedata[`MODE_ALCFG_BIT];
			end
			`OFS_ENH_CONFIG:  unsigned_format_select_r <= writedata[`ENH_USF_BIT];
			`OFS_LOCAL_HIGH:  local_high_limit_r <= writedata[7:0];
			`OFS_REM_HIGH_HI: remote_high_r[15:8] <= writedata[7:0];
			`OFS_REM_HIGH_LO: remote_high_r[7:5] <= writedata[7:5];
			`OFS_REM_LOW_HI:  remote_low_r[15:8] <= writedata[7:0];
			`OFS_REM_LOW_LO:  remote_low_r[7:5] <= writedata[7:5];
			`OFS_CRIT_LIMIT: begin
				if (critical_limit_unlock_r)
					critical_limit_r <= writedata[7:0];
			end
			`OFS_CRIT_HYST:   critical_hysteresis_r <= writedata[7:0];
			default: begin
			end
			endcase
		end
	end

	// alert mask: software writes, hardware sets, set wins
	always @(posedge clk) begin
		if (rst) begin
			alert_mask_r <= 1'b0;
		end else begin
			if (wr_fire && address == `OFS_CONFIG)
				alert_mask_r <= writedata[`CFG_MASK_BIT];
			if (rd_fire && address == `OFS_STATUS && !comparator_mode_r
				&& pending != 8'h00)
				alert_mask_r <= 1'b1;
			if (ara_done_r)
				alert_mask_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// readings, limit comparison and status

	// capture readings and compare at each conversion end
	always @(posedge clk) begin
		if (rst) begin
			remote_temp_value_r    <= 16'h0000;
			local_temp_value_r     <= 8'h00;
			live_r                 <= 8'h00;
			critical_status_flag_r <= 1'b0;
		end else if (conv_done) begin
			remote_temp_value_r <= remote_word;
			local_temp_value_r  <= local_byte;
			live_r <= 8'h00;
			live_r[`ST_LHIGH_BIT] <= $signed(local_byte) > $signed(local_high_limit_r);
			live_r[`ST_RHIGH_BIT] <= $signed(rt13) > $signed(rh13);
			live_r[`ST_RLOW_BIT]  <= $signed(rt13) < $signed(rl13);
			live_r[`ST_CRIT_BIT]  <= over_crit;
			if (over_crit)
				critical_status_flag_r <= 1'b1;
			else if (below_clr)
				critical_status_flag_r <= 1'b0;
		end
	end

	// sticky status: read clears, a new violation sets and wins
	always @(posedge clk) begin
		if (rst) begin
			status_r <= 8'h00;
		end else begin
			if (rd_fire && address == `OFS_STATUS)
				status_r <= status_r & ~readdata[7:0];	// only bits reported are cleared
			if (conv_done) begin
				if ($signed(local_byte) > $signed(local_high_limit_r))
					status_r[`ST_LHIGH_BIT] <= 1'b1;
				if ($signed(rt13) > $signed(rh13))
					status_r[`ST_RHIGH_BIT] <= 1'b1;
				if ($signed(rt13) < $signed(rl13))
					status_r[`ST_RLOW_BIT] <= 1'b1;
				if (over_crit)
					status_r[`ST_CRIT_BIT] <= 1'b1;
				if (diode_fault)
					status_r[`ST_DFAULT_BIT] <= 1'b1;
			end
			status_r[`ST_BUSY_BIT] <= conv_busy;	// live, never sticky
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// alert and critical outputs

	// comparator follows live conditions, interrupt follows sticky status
	assign alert_active = ~alert_mask_r &
		(comparator_mode_r ? ((live_r & `ST_ALERT_MASK) != 8'h00)
			: (pending != 8'h00));
	assign alert_out = 1'b0;
	assign alert_oe = alert_active;
	assign critical_temp_out = 1'b0;
	assign critical_temp_oe = critical_status_flag_r;

	////////////////////////////////////////////////////////////////////////////////
	// smbus target: never drives the clock, never stretches

	assign smb_dat_out = 1'b0;
	assign smb_dat_oe = sda_oe_r;

	// bit engine, data changes only while the clock is low
	always @(posedge clk) begin
		if (rst) begin
			scl_d_r     <= 1'b1;
			sda_d_r     <= 1'b1;
			smb_state_r <= S_IDLE;
			bit_cnt_r   <= 4'h0;
			shreg_r     <= 8'h00;
			sda_oe_r    <= 1'b0;
			rd_mode_r   <= 1'b0;
			ara_mode_r  <= 1'b0;
			ara_done_r  <= 1'b0;
		end else begin
			scl_d_r    <= scl;
			sda_d_r    <= sda;
			ara_done_r <= 1'b0;
			if (start_c) begin
				smb_state_r <= S_ADDR;	// start or repeated start
				bit_cnt_r   <= 4'h0;
				sda_oe_r    <= 1'b0;
			end else if (stop_c) begin
				smb_state_r <= S_IDLE;
				sda_oe_r    <= 1'b0;
			end else begin
				case (smb_state_r)
				S_IDLE: begin
				end
				S_ADDR, S_RX: begin
					if (scl_rise) begin
						shreg_r   <= {shreg_r[6:0], sda};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall && bit_cnt_r == 4'h8) begin
						if (smb_state_r == S_RX) begin
							smb_state_r <= S_ACK;	// accept and discard data
							sda_oe_r    <= 1'b1;
						end else if (shreg_r[7:1] == `SMB_OWN_ADDR) begin
							smb_state_r <= S_ACK;
							sda_oe_r    <= 1'b1;
							rd_mode_r   <= shreg_r[0];
							ara_mode_r  <= 1'b0;
						end else if (shreg_r == {`SMB_ARA_ADDR, 1'b1} && alert_active
							&& !alert_config_r) begin
							smb_state_r <= S_ACK;
							sda_oe_r    <= 1'b1;
							rd_mode_r   <= 1'b1;
							ara_mode_r  <= 1'b1;
						end else begin
							smb_state_r <= S_IDLE;	// not for us
						end
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						bit_cnt_r <= 4'h0;
						if (rd_mode_r) begin
							shreg_r     <= ara_mode_r ? {`SMB_OWN_ADDR, 1'b0} : 8'h00;
							sda_oe_r    <= ara_mode_r ? ((`SMB_OWN_ADDR & 7'h40) == 7'h00) : 1'b1;
							smb_state_r <= S_TX;
						end else begin
							sda_oe_r    <= 1'b0;
							smb_state_r <= S_RX;
						end
					end
				end
				S_TX: begin
					if (scl_rise && !sda_oe_r && !sda) begin
						smb_state_r <= S_IDLE;	// lost arbitration to a lower address
					end else if (scl_fall) begin
						shreg_r   <= {shreg_r[6:0], 1'b0};
						bit_cnt_r <= bit_cnt_r + 4'h1;
						if (bit_cnt_r == 4'h7) begin
							sda_oe_r    <= 1'b0;
							smb_state_r <= S_RACK;
						end else begin
							sda_oe_r <= ~shreg_r[6];
						end
					end
				end
				S_RACK: begin
					if (scl_rise) begin
						if (sda) begin
							ara_done_r  <= ara_mode_r;
							smb_state_r <= S_IDLE;	// nack ends the read
						end else begin
							smb_state_r <= S_NEXT;
						end
					end
				end
				S_NEXT: begin
					if (scl_fall) begin
						shreg_r     <= ara_mode_r ? {`SMB_OWN_ADDR, 1'b0} : 8'h00;
						sda_oe_r    <= ara_mode_r ? ((`SMB_OWN_ADDR & 7'h40) == 7'h00) : 1'b1;
						bit_cnt_r   <= 4'h0;
						smb_state_r <= S_TX;
					end
				end
				default: begin
					smb_state_r <= S_IDLE;
					sda_oe_r    <= 1'b0;
				end
				endcase
			end
		end
	end
endmodule

// ===== temp_alert_crit_asserts.sv
// checker for alert, critical and bus timing of the signalling block
`timescale 1ns/1ns
module temp_alert_crit_asserts (
	input logic        clk,
	input logic        rst,
	input logic [3:0]  address,
	input logic        read,
	input logic        write,
	input logic [31:0] writedata,
	input logic        waitrequest,
	input logic        conv_done,
	input logic        smb_clk,
	input logic        smb_dat_in,
	input logic        smb_dat_oe,
	input logic        alert_out,
	input logic        alert_oe,
	input logic        critical_temp_out,
	input logic        critical_temp_oe
);
	logic cmp_r;   // shadow of comparator mode bit
	logic frame_r; // smbus frame open
	logic sda_r;   // data level one cycle ago
	wire  wr_done = write && !waitrequest;
	wire  rd_stat = read && !waitrequest && address == 4'h3;
	////////////////////////////////////////////////////////////
	// mode shadow and start/stop tracking
	always @(posedge clk) begin
		sda_r <= smb_dat_in;
		if (rst) begin
			cmp_r   <= 1'b0;
			frame_r <= 1'b0;
		end else begin
			if (wr_done && address == 4'h5)
				cmp_r <= writedata[0];
			if (smb_clk && sda_r && !smb_dat_in)
				frame_r <= 1'b1;
			else if (smb_clk && !sda_r && smb_dat_in)
				frame_r <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_req_start;
		$rose(read || write);
	endsequence
	sequence s_mask_write;
		wr_done && address == 4'h4 && writedata[7];
	endsequence
	a_wait_first_cycle: assert property (s_req_start |-> waitrequest)
		else $error("no wait cycle at request start");
	a_wait_one_cycle: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("wait lasted over one cycle");
	a_od_low_only: assert property (!alert_out && !critical_temp_out)
		else $error("open-drain output drives high");
	a_dat_in_frame: assert property (smb_dat_oe |-> frame_r)
		else $error("data driven outside a frame");
	a_status_rd_release: assert property (rd_stat && !cmp_r && !conv_done |=> !alert_oe)
		else $error("status read left alert asserted");
	a_mask_wr_off: assert property (s_mask_write |=> !alert_oe)
		else $error("mask did not disable alert");
	a_alert_rise_cause: assert property ($rose(alert_oe) |-> $past(conv_done) || $past(wr_done))
		else $error("alert rose without cause");
	a_alert_latched: assert property ($fell(alert_oe) && !cmp_r |->
		$past(wr_done) || $past(rd_stat) || frame_r)
		else $error("latched alert fell by itself");
	a_crit_on_conv: assert property ($changed(critical_temp_oe) |-> $past(conv_done))
		else $error("critical output moved between readings");
endmodule
bind temp_alert_crit temp_alert_crit_asserts u_chk (.clk, .rst, .address, .read, .write,
	.writedata, .waitrequest, .conv_done, .smb_clk, .smb_dat_in, .smb_dat_oe, .alert_out,
	.alert_oe, .critical_temp_out, .critical_temp_oe);

// ===== smb_host_model.sv
// smbus host model that services alerts on the two-wire link
`timescale 1ns/1ns
module smb_host_model (
	input  logic clk,
	input  logic sda,
	output logic scl,
	output logic pull
);
	localparam logic [6:0] ARA_ADDR = 7'h0C;
	// idle: clock stands high, data released
	initial begin
		scl  = 1'b1;
		pull = 1'b0;
	end
	// a quarter of the 800 ns link period
	task automatic qtr;
		repeat (2) @(posedge clk);
	endtask
	// one bit: set data in middle of clock low, sample in middle of clock high
	task automatic bit_io(input logic b, output logic r);
		pull <= ~b;
		qtr();
		scl <= 1'b1;
		qtr();
		r = sda;
		qtr();
		scl <= 1'b0;
		qtr();
	endtask
	// address byte, ack, then one data byte on a read
	task automatic xfer(input logic [7:0] ab, output logic ack, output logic [7:0] d);
		logic r;
		int   i;
		@(posedge clk);
		pull <= 1'b1; // start while clock high
		qtr();
		scl <= 1'b0;
		qtr();
		for (i = 7; i >= 0; i--)
			bit_io(ab[i], r);
		bit_io(1'b1, r);
		ack = !r;
		d = 8'h00;
		if (ack && ab[0]) begin
			for (i = 7; i >= 0; i--) begin
				bit_io(1'b1, r);
				d[i] = r;
			end
			bit_io(1'b1, r); // not-acknowledge after the byte
		end
		pull <= 1'b1;
		qtr();
		scl <= 1'b1;
		qtr();
		pull <= 1'b0; // stop closes the frame
		qtr();
		@(negedge clk);
	endtask
	// alert response read
	task automatic ara(output logic ack, output logic [7:0] d);
		xfer({ARA_ADDR, 1'b1}, ack, d);
	endtask
endmodule

// ===== tb_temp_alert_crit.sv
// self-checking bench for the alert and critical signalling block
`timescale 1ns/1ns
module tb_temp_alert_crit;
	logic        clk = 0, rst = 1, read = 0, write = 0, conv_done = 0, diode_fault = 0, busy = 0;
	logic [3:0]  address = 4'h0;
	logic [31:0] writedata = 32'h0, readdata, rd;
	logic [15:0] remote_meas = 16'h0;
	logic [11:0] local_meas = 12'h0;
	logic        waitrequest, dat_out, dat_oe, alert_out, alert_oe, crit_out, crit_oe;
	logic        scl, pull, ack;
	logic [7:0]  sd;
	wire         sda = ~((dat_oe & ~dat_out) | pull); // pull-up when released
	int          fail_count = 0, samples_checked = 0, cycles = 0;
	localparam logic [15:0] NR = 16'h00C8; // 25 degrees remote
	temp_alert_crit dut (.clk(clk), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .conv_done(conv_done), .remote_meas(remote_meas),
		.local_meas(local_meas), .conv_busy(busy), .diode_fault(diode_fault),
		.smb_clk(scl), .smb_dat_in(sda), .smb_dat_out(dat_out), .smb_dat_oe(dat_oe),
		.alert_out(alert_out), .alert_oe(alert_oe), .critical_temp_out(crit_out),
		.critical_temp_oe(crit_oe));
	smb_host_model host (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
	initial forever #50 clk = ~clk;
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one avalon access, held until waitrequest is low
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		address <= a;
		writedata <= {24'h0, d};
		read <= !w;
		write <= w;
		do @(posedge clk); while (waitrequest);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(negedge clk);
	endtask
	// one conversion result
	task automatic conv(input logic [15:0] rm, input logic [11:0] lm);
		@(posedge clk);
		remote_meas <= rm;
		local_meas <= lm;
		conv_done <= 1'b1;
		@(posedge clk);
		conv_done <= 1'b0;
		@(negedge clk);
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [7:0] rv [0:11];
		rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h46, 8'h55, 8'h00, 8'h00, 8'h00, 8'h55,
			8'h0A, 8'h00};
		for (int i = 0; i < 12; i++) begin
			bus(0, 4'(i + 3), 8'h00);
			chk(rd, {24'h0, rv[i]});
		end
		bus(1, 4'hC, 8'h20);
		bus(0, 4'hC, 8'h00);
		chk(rd, 32'h55);
		bus(1, 4'h4, 8'h02);
		bus(1, 4'hC, 8'h64);
		bus(0, 4'hC, 8'h00);
		chk(rd, 32'h64);
		$display("reset and lock test done");
	endtask
	task automatic critical_limit;
		bus(1, 4'hD, 8'h05);
		conv(16'h0327, 12'd20);
		chk(crit_oe, 1'b0);
		conv(16'h0328, 12'd20);
		chk(crit_oe, 1'b1);
		conv(16'h0300, 12'd20);
		chk(crit_oe, 1'b1);
		conv(16'h02F8, 12'd20);
		chk(crit_oe, 1'b0);
		$display("critical test done");
	endtask
	task automatic t_format;
		conv(16'h03E8, 12'd200);
		bus(0, 4'h1, 8'h00);
		chk(rd, 32'h7D);
		bus(0, 4'h0, 8'h00);
		chk(rd, 32'h7F);
		conv(16'hFFFF, 12'd20);
		bus(0, 4'h2, 8'h00);
		chk(rd, 32'hE0);
		conv(16'h0960, 12'd20);
		bus(0, 4'h1, 8'h00);
		chk(rd, 32'h7F);
		bus(1, 4'h6, 8'h08);
		conv(16'h0960, 12'd20);
		bus(0, 4'h1, 8'h00);
		chk(rd, 32'hFF);
		chk(crit_oe, 1'b1);
		bus(1, 4'h6, 8'h00);
		$display("format test done");
	endtask
	task automatic t_intr;
		conv(NR, 12'd20);
		bus(0, 4'h3, 8'h00);
		bus(1, 4'h4, 8'h82);
		bus(1, 4'h4, 8'h02);
		@(posedge clk);
		diode_fault <= 1'b1;
		busy <= 1'b1; // busy and diode fault never raise the alert
		conv(NR, 12'd20);
		chk(alert_oe, 1'b0);
		@(posedge clk);
		diode_fault <= 1'b0;
		busy <= 1'b0;
		bus(0, 4'h3, 8'h00);
		chk(rd, 32'h01);
		conv(NR, 12'd80);
		chk(alert_oe, 1'b1);
		conv(NR, 12'd20);
		chk(alert_oe, 1'b1);
		bus(0, 4'h3, 8'h00);
		chk(rd, 32'h10);
		chk(alert_oe, 1'b0);
		bus(0, 4'h4, 8'h00);
		chk(rd, 32'h82);
		bus(0, 4'h3, 8'h00);
		chk(rd, 32'h00);
		conv(NR, 12'd80);
		chk(alert_oe, 1'b0);
		bus(1, 4'h4, 8'h02); // host re-enables
		chk(alert_oe, 1'b1);
		$display("interrupt test done");
	endtask
	task automatic t_cmp;
		bus(0, 4'h3, 8'h00);
		bus(1, 4'h4, 8'h02);
		bus(1, 4'h5, 8'h01);
		conv(NR, 12'd80);
		chk(alert_oe, 1'b1);
		conv(NR, 12'd20);
		chk(alert_oe, 1'b0);
		bus(0, 4'h3, 8'h00);
		bus(0, 4'h4, 8'h00);
		chk(rd, 32'h02);
		bus(1, 4'h5, 8'h00);
		$display("comparator test done");
	endtask
	task automatic t_ara;
		conv(NR, 12'd80);
		bus(1, 4'h5, 8'h02);
		host.ara(ack, sd);
		chk(ack, 1'b0);
		bus(1, 4'h5, 8'h00);
		host.ara(ack, sd);
		chk(ack, 1'b1);
		chk(sd, 8'h98);
		chk(alert_oe, 1'b0);
		bus(0, 4'h4, 8'h00);
		chk(rd, 32'h82);
		host.xfer(8'h99, ack, sd);
		chk({ack, sd}, 9'h100);
		host.xfer(8'h9B, ack, sd);
		chk(ack, 1'b0);
		bus(0, 4'h3, 8'h00); // service read, then unmask
		bus(1, 4'h4, 8'h02);
		chk(alert_oe, 1'b0);
		$display("alert response test done");
	endtask
	////////////////////////////////////////////////////////////
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		critical_limit();
		t_format();
		t_intr();
		t_cmp();
		t_ara();
		complete_run();
	end
	// hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fail_count++;
			complete_run();
		end
	end
endmodule
